// >>> design/bmpc_pkg.sv
/*
 * bmpc_pkg: shared constants and carrier types for the battery monitor
 * bus and power control block.
 * Assumes a 125 MHz core clock; all long counts derive from it.
 */
// Functional notes
// - both lines low two seconds: bus off
// - leave bus off when a line rises
// - bus ready within one millisecond after
// - both lines low five seconds: calibrate
// - sample system present once per second
// - present input low records host present
// - refresh cell voltages every second (code: every second in normal mode only, at the set interval in sleep)
// - normal mode runs cycle every second
// - sleep mode runs cycle at set interval
// - current or fault wakes from sleep
// - shutdown stops measuring, protecting, talking
// - secondary fault drives fuse output
// - fuse pin read back as blown
// - balancing enables weak cell tap pull-down
// - accumulate current in charge counter
// - positive sense charging, negative discharging
// - clock low past timeout aborts transaction
// - both lines high over 50 us resets
// - idle reset only when disable bit clear
package bmpc_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
	// bus off: least 2 s
	localparam int unsigned BUS_OFF_S      = 2;
	// ready after bus off cleared: at most 1 ms
	localparam int unsigned BUS_READY_MS   = 1;
	localparam int unsigned BUS_READY_CYC  = BUS_READY_MS * CLK_PER_MS;
	// auto calibration: least 5 s
	localparam int unsigned CALIB_S        = 5;
	// clock low timeout, 25 to 35 ms; 30 ms chosen inside the window
	localparam int unsigned TIMEOUT_MS     = 30;
	localparam int unsigned TIMEOUT_CYC    = TIMEOUT_MS * CLK_PER_MS;
	// idle reset: more than 50 us
	localparam int unsigned IDLE_US        = 50;
	localparam int unsigned IDLE_CYC       = IDLE_US * (CLK_HZ / 1_000_000);
	// periodic schedule of one second
	localparam int unsigned TICK_S         = 1;
	localparam int unsigned SEC_CYC        = TICK_S * CLK_HZ;
	// default sleep interval in seconds
	localparam logic [7:0]  SLEEP_IVL_RST  = 8'h0a;
	// counter widths
	localparam int unsigned CNT_W          = 32;
	localparam int unsigned ACC_W          = 32;
	localparam int unsigned CELLS          = 4;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PWR_NORMAL   = 3'b001,
		PWR_SLEEP    = 3'b010,
		PWR_SHUTDOWN = 3'b100
	} bmpc_pwr_t;

	typedef struct packed {
		logic busOff;
		logic busReady;
		logic calibStart;
		logic timeoutErr;
		logic idleReset;
	} bmpc_bus_stat_t;

	typedef struct packed {
		logic measure;
		logic chargeAct;
		logic dischargeAct;
	} bmpc_meas_t;

endpackage

// >>> design/bmpc_sync.sv
/*
 * bmpc_sync: two flip-flop level synchroniser, one per bit.
 * Assumes inputs are asynchronous to clk; output lags two edges.
 */
`timescale 1ns/1ps
`default_nettype none
module bmpc_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// data
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	// first stage read only by second
	logic [W-1:0] meta_q;

	// ---------------------------------------------------------------
	// two stage capture
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule
`default_nettype wire

// >>> design/bmpc_timer.sv
/*
 * bmpc_timer: saturating run-length counter; counts while run is high,
 * clears when it drops, flags once count reaches limit.
 * Assumes run comes from synchronised logic.
 */
`timescale 1ns/1ps
`default_nettype none
module bmpc_timer #(
	parameter int unsigned W = 32
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// control
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	// result
	output var  logic         reached
);
	logic [W-1:0] cnt_q;   // run length so far
	logic [W-1:0] cnt_d;
	wire          atLimit = (cnt_q >= limit);

	// saturate so the flag cannot wrap off
	assign cnt_d = !run ? '0 : (atLimit ? cnt_q : cnt_q + 1'b1);

	// ---------------------------------------------------------------
	// count register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q   <= '0;
			reached <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			reached <= run && (cnt_d >= limit);
		end
	end
endmodule
`default_nettype wire

// >>> design/bmpc_ctrl.sv
/*
 * bmpc_ctrl: bus state watch, power mode sequencer, fuse and
 * balancing drive, charge counter of the battery monitor.
 * Assumes bus lines, present, fuse sense are raw pins; sense sign,
 * fault and balance requests come from logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module bmpc_ctrl #(
	parameter int unsigned SEC_CYC     = bmpc_pkg::SEC_CYC,
	parameter int unsigned TIMEOUT_CYC = bmpc_pkg::TIMEOUT_CYC,
	parameter int unsigned READY_CYC   = bmpc_pkg::BUS_READY_CYC,
	parameter int unsigned CELLS       = bmpc_pkg::CELLS,
	parameter int unsigned ACC_W       = bmpc_pkg::ACC_W
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// bus pins, sampled only (open drain driven elsewhere)
	input  wire logic                     bus_clock_line,
	input  wire logic                     bus_data_line,
	input  wire logic                     bus_timeout_disable,
	input  wire logic                     busActive,
	// system present pin, active low
	input  wire logic                     system_present_n,
	// power control
	input  wire logic                     sleepReq,
	input  wire logic                     shutdownReq,
	input  wire logic [7:0]               sleepInterval,
	input  wire logic                     currentFlow,
	input  wire logic                     faultDetect,
	// measurement inputs
	input  wire logic                     senseValid,
	input  wire logic signed [15:0]       senseSample,
	// fuse
	input  wire logic                     secondaryFault,
	input  wire logic                     fuseSenseIn,
	output logic                          fuseOut,
	output logic                          fuseOe,
	output logic                          fuseBlown,
	// balancing
	input  wire logic [CELLS-1:0]         balanceReq,
	output logic [CELLS-1:0]              cellTapPulldown,
	// status
	output bmpc_pkg::bmpc_bus_stat_t      busStat,
	output bmpc_pkg::bmpc_meas_t          measStat,
	output bmpc_pkg::bmpc_pwr_t           pwrMode,
	output logic                          hostPresent,
	output logic                          cellUpdate,
	output logic signed [ACC_W-1:0]       chargeCount
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] pinSync;   // clock, data, present, fuse sense
	bmpc_sync #(.W(4)) uSync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({bus_clock_line, bus_data_line, system_present_n, fuseSenseIn}),
		.dout (pinSync)
	);
	wire sclS = pinSync[3];
	wire sdaS = pinSync[2];
	wire presS = pinSync[1];
	wire fuseS = pinSync[0];

	wire isShutdown = (pwrMode == bmpc_pkg::PWR_SHUTDOWN);
	wire bothLow    = !sclS && !sdaS;
	wire bothHigh   = sclS && sdaS;

	// ---------------------------------------------------------------
	// one second tick, cycle counted
	// ---------------------------------------------------------------
	logic [31:0] sec_q;    // cycles into current second
	wire         secTick = (sec_q == 32'(SEC_CYC - 1));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) sec_q <= '0;
		else       sec_q <= secTick ? '0 : sec_q + 1'b1;
	end

	// ---------------------------------------------------------------
	// long low timers: bus off and calibration
	// ---------------------------------------------------------------
	wire offReached;
	wire calReached;
	bmpc_timer #(.W(32)) uOffTmr (
		.clk     (clk),
		.rstn    (rstn),
		.run     (bothLow),
		.limit   (32'(bmpc_pkg::BUS_OFF_S * SEC_CYC)),
		.reached (offReached)
	);
	bmpc_timer #(.W(32)) uCalTmr (
		.clk     (clk),
		.rstn    (rstn),
		.run     (bothLow),
		.limit   (32'(bmpc_pkg::CALIB_S * SEC_CYC)),
		.reached (calReached)
	);

	// short timers: clock low timeout and idle
	wire toReached;
	wire idleReached;
	bmpc_timer #(.W(32)) uToTmr (
		.clk     (clk),
		.rstn    (rstn),
		.run     (!sclS && busActive),
		.limit   (32'(TIMEOUT_CYC)),
		.reached (toReached)
	);
	bmpc_timer #(.W(32)) uIdleTmr (
		.clk     (clk),
		.rstn    (rstn),
		.run     (bothHigh && !bus_timeout_disable),
		.limit   (32'(bmpc_pkg::IDLE_CYC + 1)),
		.reached (idleReached)
	);

	// ---------------------------------------------------------------
	// bus off state and ready delay
	// ---------------------------------------------------------------
	logic        busOff_q;     // bus off held
	logic        calDone_q;    // one calibration per low stretch
	logic        calPulse_q;   // calibration start strobe
	logic [31:0] rdy_q;        // cycles left to ready
	logic        toErr_q;
	logic        idleRst_q;
	logic        toSeen_q;
	logic        idleSeen_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busOff_q <= 1'b0;
		end else if (busOff_q) begin
			if (sclS || sdaS) busOff_q <= 1'b0;
		end else if (offReached) begin
			busOff_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)                        rdy_q <= '0;
		else if (busOff_q && (sclS || sdaS)) rdy_q <= 32'(READY_CYC - 1);
		else if (rdy_q != '0)             rdy_q <= rdy_q - 1'b1;
	end

	// one start strobe per low stretch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			calDone_q  <= 1'b0;
			calPulse_q <= 1'b0;
		end else begin
			calPulse_q <= calReached && !calDone_q && !isShutdown;
			calDone_q  <= bothLow && (calDone_q || calReached);
		end
	end

	// timeout and idle pulses, once per stretch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			toErr_q    <= 1'b0;
			idleRst_q  <= 1'b0;
			toSeen_q   <= 1'b0;
			idleSeen_q <= 1'b0;
		end else begin
			toErr_q    <= toReached && !toSeen_q;
			toSeen_q   <= toReached;
			idleRst_q  <= idleReached && !idleSeen_q;
			idleSeen_q <= idleReached;
		end
	end

	assign busStat.busOff     = busOff_q;
	assign busStat.busReady   = !busOff_q && (rdy_q == '0) && !isShutdown;
	assign busStat.calibStart = calPulse_q;
	assign busStat.timeoutErr = toErr_q && !isShutdown;
	assign busStat.idleReset  = idleRst_q && !isShutdown;

	// ---------------------------------------------------------------
	// power mode sequencer
	// ---------------------------------------------------------------
	bmpc_pkg::bmpc_pwr_t pwr_d;
	always_comb begin
		pwr_d = pwrMode;
		case (pwrMode)
			bmpc_pkg::PWR_NORMAL: begin
				if (shutdownReq)   pwr_d = bmpc_pkg::PWR_SHUTDOWN;
				else if (sleepReq) pwr_d = bmpc_pkg::PWR_SLEEP;
			end
			bmpc_pkg::PWR_SLEEP: begin
				if (shutdownReq)                     pwr_d = bmpc_pkg::PWR_SHUTDOWN;
				else if (currentFlow || faultDetect) pwr_d = bmpc_pkg::PWR_NORMAL;
			end
			// shutdown leaves only through reset
			bmpc_pkg::PWR_SHUTDOWN: pwr_d = bmpc_pkg::PWR_SHUTDOWN;
			default:                pwr_d = bmpc_pkg::PWR_NORMAL;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) pwrMode <= bmpc_pkg::PWR_NORMAL;
		else       pwrMode <= pwr_d;
	end

	// ---------------------------------------------------------------
	// measurement cycle scheduling
	// ---------------------------------------------------------------
	logic [7:0] slp_q;   // seconds since last sleep cycle
	wire        slpDue = (slp_q + 8'h01 >= sleepInterval);
	wire        cycleNow = secTick && (pwrMode == bmpc_pkg::PWR_NORMAL
	                       || (pwrMode == bmpc_pkg::PWR_SLEEP && slpDue));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)                                 slp_q <= '0;
		else if (pwrMode != bmpc_pkg::PWR_SLEEP)   slp_q <= '0;
		else if (secTick)                          slp_q <= slpDue ? '0 : slp_q + 8'h01;
	end

	logic measure_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			measure_q  <= 1'b0;
			cellUpdate <= 1'b0;
		end else begin
			measure_q  <= cycleNow;
			cellUpdate <= cycleNow;
		end
	end

	// ---------------------------------------------------------------
	// system present poll
	// ---------------------------------------------------------------
	// sample on the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)                       hostPresent <= 1'b0;
		else if (secTick && !isShutdown) hostPresent <= !presS;
	end

	// ---------------------------------------------------------------
	// charge counter and direction
	// ---------------------------------------------------------------
	logic chg_q;
	logic dis_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chargeCount <= '0;
			chg_q       <= 1'b0;
			dis_q       <= 1'b0;
		end else if (senseValid && !isShutdown) begin
			chargeCount <= chargeCount + ACC_W'(senseSample);
			chg_q       <= (senseSample > 0);
			dis_q       <= (senseSample < 0);
		end
	end
	assign measStat.measure      = measure_q;
	assign measStat.chargeAct    = chg_q;
	assign measStat.dischargeAct = dis_q;

	// ---------------------------------------------------------------
	// fuse drive and sense
	// ---------------------------------------------------------------
	logic fuseFire_q;   // latched, blow is permanent
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fuseFire_q <= 1'b0;
			fuseBlown  <= 1'b0;
		end else begin
			if (secondaryFault && !isShutdown) fuseFire_q <= 1'b1;
			fuseBlown <= fuseS;
		end
	end
	assign fuseOut = fuseFire_q;
	assign fuseOe  = fuseFire_q;

	// ---------------------------------------------------------------
	// cell balancing pull-downs
	// ---------------------------------------------------------------
	// weak pull-down per tap
	genvar gi;
	generate
		for (gi = 0; gi < CELLS; gi++) begin : gBal
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) cellTapPulldown[gi] <= 1'b0;
				else       cellTapPulldown[gi] <= balanceReq[gi] && !isShutdown;
			end
		end
	endgenerate
endmodule
`default_nettype wire

// >>> sim/bmpc_ctrl_props.sv
/*
 * bmpc_ctrl_props: timing and sequencing checks on the control block ports.
 * Assumes the bind hands on the shortened counts used by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module bmpc_ctrl_props #(
	parameter int unsigned SEC_CYC     = 1000,
	parameter int unsigned TIMEOUT_CYC = 200,
	parameter int unsigned READY_CYC   = 20,
	parameter int unsigned ACC_W       = 32
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// bus and control inputs
	input  wire logic                   bus_clock_line,
	input  wire logic                   bus_data_line,
	input  wire logic                   bus_timeout_disable,
	input  wire logic                   busActive,
	input  wire logic                   sleepReq,
	input  wire logic                   shutdownReq,
	input  wire logic                   currentFlow,
	input  wire logic                   faultDetect,
	input  wire logic                   senseValid,
	input  wire logic signed [15:0]     senseSample,
	input  wire logic                   secondaryFault,
	// observed outputs
	input  wire logic                   fuseOut,
	input  wire logic                   fuseOe,
	input  wire bmpc_pkg::bmpc_bus_stat_t busStat,
	input  wire bmpc_pkg::bmpc_meas_t   measStat,
	input  wire bmpc_pkg::bmpc_pwr_t    pwrMode,
	input  wire logic                   cellUpdate,
	input  wire logic signed [ACC_W-1:0] chargeCount
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ---------------------------------------------------------------
	// run-length helpers on the raw pins and on the status outputs (raw pin counts lead the synced ones)
	// ---------------------------------------------------------------
	logic [31:0] lowRun_q, clkLow_q, hiRun_q, gap_q, rdy_q;
	logic        seen_q; // a normal-mode pulse was seen since entering normal
	wire logic   isNorm = (pwrMode == bmpc_pkg::PWR_NORMAL);
	wire logic   isShut = (pwrMode == bmpc_pkg::PWR_SHUTDOWN);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{lowRun_q, clkLow_q, hiRun_q, gap_q, rdy_q, seen_q} <= '0;
		end else begin
			lowRun_q <= (!bus_clock_line && !bus_data_line) ? lowRun_q + 1 : '0;
			clkLow_q <= (!bus_clock_line && busActive) ? clkLow_q + 1 : '0;
			hiRun_q  <= (bus_clock_line && bus_data_line) ? hiRun_q + 1 : '0;
			gap_q    <= (measStat.measure || !isNorm) ? '0 : gap_q + 1;
			seen_q   <= isNorm && (seen_q || measStat.measure);
			rdy_q    <= (busStat.busOff || busStat.busReady || isShut) ? '0 : rdy_q + 1;
		end
	end
	a_busoff_late: assert property ($rose(busStat.busOff) |-> lowRun_q >= 2*SEC_CYC)
		else $error("bus off entered too early");
	a_busoff_due: assert property (lowRun_q == 2*SEC_CYC + 8 |-> busStat.busOff)
		else $error("bus off missing after long low");
	a_busoff_clear: assert property (busStat.busOff && (bus_clock_line || bus_data_line)
		|-> ##[1:5] !busStat.busOff)
		else $error("bus off not cleared by rising line");
	a_ready_bound: assert property (rdy_q <= READY_CYC + 4)
		else $error("bus not ready in time after bus off");
	a_calib_late: assert property (busStat.calibStart |-> lowRun_q >= 5*SEC_CYC)
		else $error("calibration started too early");
	a_meas_period: assert property (measStat.measure && isNorm && seen_q
		|-> gap_q == SEC_CYC - 1)
		else $error("normal cycle period wrong");
	a_meas_due: assert property (isNorm |-> gap_q <= SEC_CYC + 3)
		else $error("normal cycle missing");
	a_shut_quiet: assert property (isShut && $past(isShut) |-> !(measStat.measure || cellUpdate
		|| busStat.calibStart || busStat.timeoutErr || busStat.idleReset || busStat.busReady))
		else $error("activity during shutdown");
	a_shut_stays: assert property (shutdownReq || isShut |=> isShut)
		else $error("shutdown not entered or left");
	a_wake_path: assert property (pwrMode == bmpc_pkg::PWR_SLEEP && (currentFlow || faultDetect)
		&& !sleepReq && !shutdownReq |=> isNorm)
		else $error("no wake from sleep");
	a_fuse_sticky: assert property (secondaryFault || fuseOut |=> fuseOut && fuseOe)
		else $error("fuse drive missing or dropped");
	a_charge_sum: assert property (senseValid && !isShut
		|=> chargeCount == $past(chargeCount) + $past(senseSample))
		else $error("charge counter sum wrong");
	a_charge_dir: assert property (senseValid && !isShut && senseSample != 0
		|=> measStat.chargeAct == ($past(senseSample) > 0)
		&& measStat.dischargeAct == ($past(senseSample) < 0))
		else $error("charge direction wrong");
	a_timeout_late: assert property (busStat.timeoutErr |-> clkLow_q >= TIMEOUT_CYC)
		else $error("timeout flagged too early");
	a_idle_gate: assert property (busStat.idleReset
		|-> !bus_timeout_disable && hiRun_q > bmpc_pkg::IDLE_CYC)
		else $error("idle reset early or while disabled");
endmodule
bind bmpc_ctrl bmpc_ctrl_props #(.SEC_CYC(SEC_CYC), .TIMEOUT_CYC(TIMEOUT_CYC),
	.READY_CYC(READY_CYC), .ACC_W(ACC_W)) props_u (.clk, .rstn, .bus_clock_line,
	.bus_data_line, .bus_timeout_disable, .busActive, .sleepReq, .shutdownReq,
	.currentFlow, .faultDetect, .senseValid, .senseSample, .secondaryFault, .fuseOut,
	.fuseOe, .busStat, .measStat, .pwrMode, .cellUpdate, .chargeCount);
`default_nettype wire

// >>> sim/bmpc_host_model.sv
/*
 * bmpc_host_model: system host on the two-wire bus, mode set by the bench.
 * Assumes pull-ups on both lines, so a released line reads high.
 */
`timescale 1ns/1ps
`default_nettype none
module bmpc_host_model (
	// 0 release, 1 both low, 2 clock low, 3 frame
	input  wire logic [1:0] hostMode,
	// bus lines
	output var  logic       clockLine,
	output var  logic       dataLine
);
	logic tog = 1'b0; // 80 ns bit clock, on the line only inside frames
	initial begin
		#13;
		forever #40 tog = ~tog;
	end
	// host wake: release lets the pull-ups lift both lines
	assign clockLine = (hostMode == 2'h0) ? 1'b1 : (hostMode == 2'h3) ? tog : 1'b0;
	assign dataLine  = (hostMode == 2'h3) ? ~tog : (hostMode != 2'h1);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
/*
 * tb_top: self-checking bench for the control block with a host model.
 * Assumes shortened second, timeout and ready counts set below.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int SEC = 1000; // cycles standing for one second
	localparam int TMO = 200;
	localparam int RDY = 20;
	logic clk, rstn, busActive, toDis, presN, sleepReq, shutReq, curFlow, fault, sv;
	logic secFault, fuseIn, fuseOut, fuseOe, fuseBlown, hostPres, cellUpd;
	logic [7:0] ivl;
	logic signed [15:0] ss;
	logic signed [31:0] chg;
	logic [3:0] bal, tap;
	logic [1:0] hostMode;
	wire logic sclk, sdat;
	bmpc_pkg::bmpc_bus_stat_t bs;
	bmpc_pkg::bmpc_meas_t ms;
	bmpc_pkg::bmpc_pwr_t pm;
	int nMismatch, checksDone;
	bmpc_host_model host_u (.hostMode(hostMode), .clockLine(sclk), .dataLine(sdat));
	bmpc_ctrl #(.SEC_CYC(SEC), .TIMEOUT_CYC(TMO), .READY_CYC(RDY)) dut_u (.clk(clk),
		.rstn(rstn), .bus_clock_line(sclk), .bus_data_line(sdat), .bus_timeout_disable(toDis),
		.busActive(busActive), .system_present_n(presN), .sleepReq(sleepReq),
		.shutdownReq(shutReq), .sleepInterval(ivl), .currentFlow(curFlow), .faultDetect(fault),
		.senseValid(sv), .senseSample(ss), .secondaryFault(secFault), .fuseSenseIn(fuseIn),
		.fuseOut(fuseOut), .fuseOe(fuseOe), .fuseBlown(fuseBlown), .balanceReq(bal),
		.cellTapPulldown(tap), .busStat(bs), .measStat(ms), .pwrMode(pm),
		.hostPresent(hostPres), .cellUpdate(cellUpd), .chargeCount(chg));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tallyAndFinish;
		$display("mismatches %0d checks %0d", nMismatch, checksDone);
		if (nMismatch == 0 && checksDone > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// a wait that used up its limit ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			nMismatch++;
			$display("ERROR %0t waited %h limit %h", $time, n, lim);
			tallyAndFinish();
		end
	endtask
	task automatic countPulses(input int cyc, output int m, output int c);
		m = 0;
		c = 0;
		repeat (cyc) begin
			@(negedge clk);
			if (ms.measure === 1'b1) m++;
			if (cellUpd === 1'b1) c++;
		end
	endtask
	task automatic tCharge;
		logic signed [15:0] v [3] = '{16'sh0064, -16'sh001e, 16'sh7fff};
		logic signed [31:0] e;
		e = 0;
		foreach (v[i]) begin
			@(posedge clk) sv <= 1'b1;
			ss <= v[i];
			@(posedge clk) sv <= 1'b0;
			@(negedge clk) e += v[i];
			chk(chg, e);
			chk(ms.dischargeAct, v[i] < 0);
		end
	endtask
	task automatic tFuseBal;
		@(negedge clk) chk(fuseBlown, 1'h0);
		@(posedge clk) secFault <= 1'b1;
		bal <= 4'h5;
		@(posedge clk) secFault <= 1'b0;
		fuseIn <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk({fuseOut, fuseOe}, 2'h3);
		chk(fuseBlown, 1'h1);
		chk(tap, 4'h5);
		@(posedge clk) bal <= 4'ha;
		repeat (2) @(posedge clk);
		@(negedge clk) chk(tap, 4'ha);
	endtask
	task automatic tPresent;
		int n;
		@(posedge clk) presN <= 1'b0;
		for (n = 0; n < SEC + 10 && hostPres !== 1'b1; n++) @(negedge clk);
		bound(n, SEC + 10);
		chk(hostPres, 1'h1);
		@(posedge clk) presN <= 1'b1;
		for (n = 0; n < SEC + 10 && hostPres !== 1'b0; n++) @(negedge clk);
		bound(n, SEC + 10);
		chk(hostPres, 1'h0);
	endtask
	task automatic tTimeout;
		int n, m;
		@(posedge clk) busActive <= 1'b1;
		hostMode <= 2'h3;
		for (n = 0; n < 2 * TMO && bs.timeoutErr !== 1'b1; n++) @(negedge clk);
		chk(n, 2 * TMO);
		@(posedge clk) hostMode <= 2'h2;
		for (n = 0; n < TMO + 10 && bs.timeoutErr !== 1'b1; n++) @(negedge clk);
		bound(n, TMO + 10);
		chk(n >= TMO - 3, 1'h1);
		@(posedge clk) busActive <= 1'b0;
		toDis <= 1'b1;
		hostMode <= 2'h0;
		// every cycle of the disabled stretch is watched, not just the last
		m = 0;
		for (n = 0; n < 7000; n++) begin
			@(negedge clk);
			if (bs.idleReset !== 1'b0) m++;
		end
		chk(m, 0);
		@(posedge clk) toDis <= 1'b0;
		hostMode <= 2'h2;
		@(posedge clk) hostMode <= 2'h0;
		for (n = 0; n < 6400 && bs.idleReset !== 1'b1; n++) @(negedge clk);
		bound(n, 6400);
		chk(n > 6250, 1'h1);
	endtask
	task automatic tBusOff;
		int n, m;
		@(posedge clk) hostMode <= 2'h1;
		for (n = 0; n < 2 * SEC + 20 && bs.busOff !== 1'b1; n++) @(negedge clk);
		bound(n, 2 * SEC + 20);
		chk(n >= 2 * SEC, 1'h1);
		for (m = n; m < 5 * SEC + 20 && bs.calibStart !== 1'b1; m++) @(negedge clk);
		bound(m, 5 * SEC + 20);
		chk(m >= 5 * SEC, 1'h1);
		@(posedge clk) hostMode <= 2'h0;
		for (n = 0; n < 8 && bs.busOff !== 1'b0; n++) @(negedge clk);
		bound(n, 8);
		for (n = 0; n < RDY + 8 && bs.busReady !== 1'b1; n++) @(negedge clk);
		bound(n, RDY + 8);
		chk(bs.busReady, 1'h1);
	endtask
	task automatic tPower;
		int m, c;
		@(posedge clk) ivl <= 8'h02;
		sleepReq <= 1'b1;
		@(posedge clk);
		@(negedge clk) chk(pm, bmpc_pkg::PWR_SLEEP);
		countPulses(4 * SEC, m, c);
		chk(m, 2);
		@(posedge clk) sleepReq <= 1'b0;
		curFlow <= 1'b1;
		@(posedge clk) curFlow <= 1'b0;
		@(negedge clk) chk(pm, bmpc_pkg::PWR_NORMAL);
		countPulses(3 * SEC, m, c);
		chk(m, 3);
		chk(c, 3);
		// second sleep, left this time through the fault wake path
		@(posedge clk) sleepReq <= 1'b1;
		@(posedge clk) sleepReq <= 1'b0;
		@(negedge clk) chk(pm, bmpc_pkg::PWR_SLEEP);
		@(posedge clk) fault <= 1'b1;
		@(posedge clk) fault <= 1'b0;
		@(negedge clk) chk(pm, bmpc_pkg::PWR_NORMAL);
		// sense pulse lands only once shutdown is in force
		@(posedge clk) shutReq <= 1'b1;
		@(posedge clk) sv <= 1'b1;
		@(posedge clk) sv <= 1'b0;
		countPulses(2 * SEC, m, c);
		chk(pm, bmpc_pkg::PWR_SHUTDOWN);
		chk(m + c, 0);
		chk(chg, 32'h0000_8045);
	endtask
	initial begin
		{rstn, busActive, toDis, sleepReq, shutReq, curFlow, fault, sv, secFault, fuseIn} = '0;
		{ivl, ss, bal, hostMode, nMismatch, checksDone} = '0;
		presN = 1'b1;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		tCharge();
		tFuseBal();
		tPresent();
		tTimeout();
		tBusOff();
		tPower();
		tallyAndFinish();
	end
endmodule
`default_nettype wire
